//--- include/scan_pkg.sv
// Constants and types shared by the boundary-scan test logic
package scan_pkg;
  localparam int          IR_LEN       = 10;
  localparam int          ID_LEN       = 32;
  localparam int          SYNC_DEPTH   = 3;
  // Instruction codes; all ones is bypass, the rest are arbitrary picks
  localparam logic [9:0]  OP_BYPASS    = 10'h3ff;
  localparam logic [9:0]  OP_SAMPLE    = 10'h005;
  localparam logic [9:0]  OP_EXTEST    = 10'h00f;
  localparam logic [9:0]  OP_IDCODE    = 10'h006;
  localparam logic [9:0]  OP_USERCODE  = 10'h007;
  localparam logic [9:0]  OP_CLAMP     = 10'h00a;
  localparam logic [9:0]  OP_HIGHZ     = 10'h00b;
  localparam logic [9:0]  OP_CONFIG_IO = 10'h00d;
  localparam logic [9:0]  OP_PULSE_CFG = 10'h001;
  // Captured into the instruction shifter, so "10..." leaves first
  localparam logic [9:0]  IR_CAPTURE   = 10'h001;
  localparam logic [9:0]  IR_RESET     = OP_IDCODE;
  // Arbitrary identification value, names no maker or part
  localparam logic [31:0] ID_VALUE     = 32'h0a5c3e01;
  localparam logic [31:0] SIG_DEFAULT  = 32'hffffffff;

  typedef enum logic [3:0] {
    TLR, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef enum logic [3:0] {
    M_BYPASS, M_SAMPLE, M_EXTEST, M_IDCODE, M_USER, M_CLAMP, M_HIGHZ,
    M_CFGIO, M_PULSE
  } mode_t;

  typedef struct packed {
    logic done;
    logic request_n;
  } cfg_status_t;
endpackage

//--- rtl/boundary_scan.sv
// Boundary-scan test logic: TAP, instruction and data registers, pin cells
`timescale 1ns/10ps
`default_nettype none
module boundary_scan #(
  parameter int PINS = 8
) (
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  input  wire logic                              clock_en,
  input  wire logic                              tck,
  input  wire logic                              trst_b,
  input  wire logic                              tms,
  input  wire logic                              tdi,
  output logic                                   tdo,
  output logic                                   tdo_oe,
  input  wire logic                              config_done,
  input  wire logic                              config_request_n,
  input  wire logic                              chip_wide_clear_n,
  input  wire logic                              chip_wide_output_enable,
  input  wire logic [scan_pkg::ID_LEN-1:0]       user_signature,
  output logic                                   config_halt,
  output logic                                   config_restart,
  input  wire logic [PINS-1:0]                   core_output_value,
  input  wire logic [PINS-1:0]                   core_output_enable,
  output logic      [PINS-1:0]                   core_input_value,
  input  wire logic [PINS-1:0]                   keeper_enable,
  input  wire logic [PINS-1:0]                   pin_in,
  output logic      [PINS-1:0]                   pin_out,
  output logic      [PINS-1:0]                   pin_oe,
  output logic      [PINS-1:0]                   pin_keep
);
  localparam int CH = 3 * PINS;

  typedef struct packed {
    scan_pkg::tap_state_t          st;
    logic [scan_pkg::IR_LEN-1:0]   ir_sh;
    logic [scan_pkg::IR_LEN-1:0]   ir;
    logic                          byp;
    logic [scan_pkg::ID_LEN-1:0]   id_sh;
    logic [CH-1:0]                 bs_cap;
    logic [CH-1:0]                 bs_upd;
    logic                          halt;
    logic                          pulse_tog;
    scan_pkg::cfg_status_t         st_s0;
    scan_pkg::cfg_status_t         st_s1;
  } tap_t;

  typedef struct packed {
    logic                          tdo;
    logic                          tdo_oe;
  } neg_t;

  typedef struct packed {
    logic [scan_pkg::SYNC_DEPTH-1:0] done_p;
    logic [scan_pkg::SYNC_DEPTH-1:0] req_p;
    scan_pkg::cfg_status_t           status;
    logic [1:0]                      halt_s;
    logic [2:0]                      tog_s;
    logic                            restart;
  } sys_t;

  tap_t                 s;
  tap_t                 next_s;
  neg_t                 ng;
  neg_t                 next_ng;
  sys_t                 y;
  sys_t                 next_y;
  scan_pkg::mode_t      mode;
  logic                 busy;
  logic                 configured;
  logic                 test_drive;
  logic [CH-1:0]        cap_vec;
  logic [PINS-1:0]      upd_out;
  logic                 in_shift;
  logic                 serial_out;
  logic                 tap_rst_b;

  // Either the device reset or the test reset pin resets the scan logic
  assign tap_rst_b = rst_b & trst_b;

  function automatic scan_pkg::mode_t decode(input logic [9:0] op, input logic bz);
    scan_pkg::mode_t m;
    m = scan_pkg::M_BYPASS;
    if (op == scan_pkg::OP_SAMPLE)         m = scan_pkg::M_SAMPLE;
    else if (op == scan_pkg::OP_IDCODE)    m = scan_pkg::M_IDCODE;
    else if (op == scan_pkg::OP_CONFIG_IO) m = scan_pkg::M_CFGIO;
    else if (bz)                           m = scan_pkg::M_BYPASS;
    else if (op == scan_pkg::OP_EXTEST)    m = scan_pkg::M_EXTEST;
    else if (op == scan_pkg::OP_USERCODE)  m = scan_pkg::M_USER;
    else if (op == scan_pkg::OP_CLAMP)     m = scan_pkg::M_CLAMP;
    else if (op == scan_pkg::OP_HIGHZ)     m = scan_pkg::M_HIGHZ;
    else if (op == scan_pkg::OP_PULSE_CFG) m = scan_pkg::M_PULSE;
    return m;
  endfunction

  assign configured = s.st_s1.done;
  // Chip-wide clear and output enable are not inputs to any of this logic
  assign busy       = !configured && !s.halt && s.st_s1.request_n;
  assign mode       = decode(s.ir, busy);
  assign test_drive = (mode == scan_pkg::M_EXTEST) || (mode == scan_pkg::M_CLAMP) ||
                      (mode == scan_pkg::M_CFGIO);
  assign in_shift   = (s.st == scan_pkg::SH_IR) || (s.st == scan_pkg::SH_DR);

  // Pin cells: bit 0 output, bit 1 output disable, bit 2 core input
  for (genvar i = 0; i < PINS; i++) begin : g_cell
    logic keep;
    assign keep = keeper_enable[i] && configured;
    assign upd_out[i] = s.bs_upd[3*i];
    assign pin_keep[i] = keep;
    assign pin_out[i] = test_drive ? s.bs_upd[3*i] : core_output_value[i];
    always_comb begin
      if (mode == scan_pkg::M_HIGHZ) begin
        pin_oe[i] = 1'b0;
      end else if (test_drive) begin
        pin_oe[i] = !s.bs_upd[3*i+1] && !(keep && mode == scan_pkg::M_CLAMP);
      end else begin
        pin_oe[i] = core_output_enable[i];
      end
    end
    assign core_input_value[i] = test_drive ? s.bs_upd[3*i+2] : pin_in[i];
    // Capture what the pin really shows, so external test sees its own drive
    assign cap_vec[3*i+2:3*i] = {pin_in[i], !pin_oe[i], pin_out[i]};
  end

  always_comb begin
    if (s.st == scan_pkg::SH_IR) begin
      serial_out = s.ir_sh[0];
    end else if (mode == scan_pkg::M_IDCODE || mode == scan_pkg::M_USER) begin
      serial_out = s.id_sh[0];
    end else if (mode == scan_pkg::M_SAMPLE || mode == scan_pkg::M_EXTEST ||
                 mode == scan_pkg::M_CFGIO) begin
      serial_out = s.bs_cap[0];
    end else begin
      serial_out = s.byp;
    end
  end

  always_comb begin
    next_s = s;
    next_s.st_s0 = y.status;
    next_s.st_s1 = s.st_s0;
    // Pin restart also ends an interrupted configuration
    if (!s.st_s1.request_n) begin
      next_s.halt = 1'b0;
    end
    case (s.st)
      scan_pkg::TLR:    next_s.st = tms ? scan_pkg::TLR : scan_pkg::IDLE;
      scan_pkg::IDLE:   next_s.st = tms ? scan_pkg::SEL_DR : scan_pkg::IDLE;
      scan_pkg::SEL_DR: next_s.st = tms ? scan_pkg::SEL_IR : scan_pkg::CAP_DR;
      scan_pkg::CAP_DR: next_s.st = tms ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
      scan_pkg::SH_DR:  next_s.st = tms ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
      scan_pkg::EX1_DR: next_s.st = tms ? scan_pkg::UPD_DR : scan_pkg::PAU_DR;
      scan_pkg::PAU_DR: next_s.st = tms ? scan_pkg::EX2_DR : scan_pkg::PAU_DR;
      scan_pkg::EX2_DR: next_s.st = tms ? scan_pkg::UPD_DR : scan_pkg::SH_DR;
      scan_pkg::UPD_DR: next_s.st = tms ? scan_pkg::SEL_DR : scan_pkg::IDLE;
      scan_pkg::SEL_IR: next_s.st = tms ? scan_pkg::TLR : scan_pkg::CAP_IR;
      scan_pkg::CAP_IR: next_s.st = tms ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
      scan_pkg::SH_IR:  next_s.st = tms ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
      scan_pkg::EX1_IR: next_s.st = tms ? scan_pkg::UPD_IR : scan_pkg::PAU_IR;
      scan_pkg::PAU_IR: next_s.st = tms ? scan_pkg::EX2_IR : scan_pkg::PAU_IR;
      scan_pkg::EX2_IR: next_s.st = tms ? scan_pkg::UPD_IR : scan_pkg::SH_IR;
      default:          next_s.st = tms ? scan_pkg::SEL_DR : scan_pkg::IDLE;
    endcase
    case (s.st)
      scan_pkg::TLR: begin
        next_s.ir = scan_pkg::IR_RESET;
      end
      scan_pkg::CAP_IR: begin
        next_s.ir_sh = scan_pkg::IR_CAPTURE;
      end
      scan_pkg::SH_IR: begin
        next_s.ir_sh = {tdi, s.ir_sh[scan_pkg::IR_LEN-1:1]};
      end
      scan_pkg::UPD_IR: begin
        next_s.ir = s.ir_sh;
        if (s.ir_sh == scan_pkg::OP_CONFIG_IO) begin
          next_s.halt = 1'b1;
        end else if (s.ir_sh == scan_pkg::OP_PULSE_CFG && !busy) begin
          next_s.halt = 1'b0;
          next_s.pulse_tog = !s.pulse_tog;
        end
      end
      scan_pkg::CAP_DR: begin
        case (mode)
          scan_pkg::M_IDCODE: next_s.id_sh = scan_pkg::ID_VALUE;
          // Signature word is stable once done is seen, so done qualifies it
          scan_pkg::M_USER:   next_s.id_sh = configured ? user_signature : scan_pkg::SIG_DEFAULT;
          scan_pkg::M_SAMPLE, scan_pkg::M_EXTEST, scan_pkg::M_CFGIO: next_s.bs_cap = cap_vec;
          default:            next_s.byp = 1'b0;
        endcase
      end
      scan_pkg::SH_DR: begin
        case (mode)
          scan_pkg::M_IDCODE, scan_pkg::M_USER:
            next_s.id_sh = {tdi, s.id_sh[scan_pkg::ID_LEN-1:1]};
          scan_pkg::M_SAMPLE, scan_pkg::M_EXTEST, scan_pkg::M_CFGIO:
            next_s.bs_cap = {tdi, s.bs_cap[CH-1:1]};
          default:
            next_s.byp = tdi;
        endcase
      end
      scan_pkg::UPD_DR: begin
        if (mode == scan_pkg::M_SAMPLE || mode == scan_pkg::M_EXTEST || mode == scan_pkg::M_CFGIO) begin
          next_s.bs_upd = s.bs_cap;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge tck or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      s <= '{st: scan_pkg::TLR, ir: scan_pkg::IR_RESET, bs_upd: '1, st_s0: '{done: 1'b0, request_n: 1'b1},
             st_s1: '{done: 1'b0, request_n: 1'b1}, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Falling-edge stage gives the tester a half period of hold on TDO
  always_comb begin
    next_ng.tdo    = serial_out;
    next_ng.tdo_oe = in_shift;
  end

  always_ff @(negedge tck or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      ng <= '0;
    end else begin
      ng <= next_ng;
    end
  end

  assign tdo    = ng.tdo;
  assign tdo_oe = ng.tdo_oe;

  // System side: pin filters and the crossings of halt and restart
  always_comb begin
    next_y = y;
    next_y.done_p = {y.done_p[1:0], config_done};
    next_y.req_p  = {y.req_p[1:0], config_request_n};
    if (y.done_p[1] == y.done_p[2]) begin
      next_y.status.done = y.done_p[2];
    end
    if (y.req_p[1] == y.req_p[2]) begin
      next_y.status.request_n = y.req_p[2];
    end
    next_y.halt_s  = {y.halt_s[0], s.halt};
    next_y.tog_s   = {y.tog_s[1:0], s.pulse_tog};
    next_y.restart = y.tog_s[1] ^ y.tog_s[2];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      y <= '{req_p: '1, status: '{done: 1'b0, request_n: 1'b1}, default: '0};
    end else if (clock_en) begin
      y <= next_y;
    end
  end

  assign config_halt    = y.halt_s[1];
  assign config_restart = y.restart;

  ir_reset_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    (s.st == scan_pkg::TLR) |=> (s.ir == scan_pkg::OP_IDCODE))
    else $error("instruction not identification after reset state");
  bypass_select_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    (s.ir == scan_pkg::OP_BYPASS) |-> (mode == scan_pkg::M_BYPASS))
    else $error("all-ones instruction did not select bypass");
  bypass_path_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    (s.st == scan_pkg::SH_DR && mode == scan_pkg::M_BYPASS) |=> (tdo == $past(tdi)))
    else $error("bypass bit did not reach tdo");
  tdo_enable_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    ##1 (tdo_oe == ((s.st == scan_pkg::SH_IR) || (s.st == scan_pkg::SH_DR))))
    else $error("tdo enable disagrees with controller state");
  highz_pins_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    (mode == scan_pkg::M_HIGHZ) |-> (pin_oe == '0))
    else $error("pin driven under high-impedance instruction");
  update_copy_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    (s.st == scan_pkg::UPD_DR && mode == scan_pkg::M_SAMPLE) |=> (s.bs_upd == $past(s.bs_cap)))
    else $error("update registers missed capture contents");
  extest_drive_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    (mode == scan_pkg::M_EXTEST) |-> (pin_out == upd_out))
    else $error("external test pins not from update registers");
  chain_shift_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    (s.st == scan_pkg::SH_DR && mode == scan_pkg::M_SAMPLE) |=>
    (s.bs_cap == {$past(tdi), $past(s.bs_cap[CH-1:1])}))
    else $error("boundary chain did not shift by one");
  usercode_default_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    (s.st == scan_pkg::CAP_DR && mode == scan_pkg::M_USER && !configured) |=>
    (s.id_sh == scan_pkg::SIG_DEFAULT))
    else $error("user code not default before configuration");
  halt_set_a: assert property (@(posedge tck) disable iff (!tap_rst_b)
    (s.st == scan_pkg::UPD_IR && s.ir_sh == scan_pkg::OP_CONFIG_IO) |=> s.halt)
    else $error("configuration not halted by interrupt instruction");
endmodule
`default_nettype wire

//--- test/boundary_scan_instruction_modes_tb.sv
// Testbench: instruction modes of the boundary-scan logic through a tester model
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_instruction_modes_tb;
  typedef struct packed {
    logic [9:0]  ir;
    logic [5:0]  len;
    logic [31:0] din;
    logic [31:0] dout;
  } row_t;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        tck, tms, tdi, trst_b, tdo, tdo_oe, halt, restart;
  logic        done = 1'b0;
  logic        req_n = 1'b1;
  logic        clear_n = 1'b1;
  logic        chip_oe = 1'b0;
  logic [3:0]  core_out = 4'h5;
  logic [3:0]  core_en = 4'h3;
  logic [3:0]  keeper = 4'h0;
  logic [3:0]  pin_in = 4'h9;
  logic [3:0]  core_in, pin_out, pin_oe, pin_keep;
  logic [31:0] sig = 32'h1234abcd;
  logic [31:0] got;
  int          error_cnt = 0;
  int          checked = 0;
  // While configuration is busy only bypass, sample, identification and I/O configuration decode
  row_t        rows [5] = '{'{scan_pkg::OP_IDCODE, 6'd32, 32'h0, scan_pkg::ID_VALUE},
                            '{scan_pkg::OP_BYPASS, 6'd4, 32'hb, 32'h6},
                            '{scan_pkg::OP_USERCODE, 6'd4, 32'hb, 32'h6},
                            '{scan_pkg::OP_EXTEST, 6'd4, 32'hb, 32'h6},
                            '{scan_pkg::OP_HIGHZ, 6'd4, 32'hb, 32'h6}};

  always #12.5 clock = ~clock;
  always @(negedge clock) begin
    clear_n <= ~clear_n;
    chip_oe <= clear_n;
  end

  boundary_scan #(.PINS(4)) DUT (
    .clock(clock), .rst_b(rst_b), .clock_en(1'b1), .tck(tck), .trst_b(trst_b), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .config_done(done), .config_request_n(req_n), .chip_wide_clear_n(clear_n),
    .chip_wide_output_enable(chip_oe), .user_signature(sig), .config_halt(halt), .config_restart(restart),
    .core_output_value(core_out), .core_output_enable(core_en), .core_input_value(core_in),
    .keeper_enable(keeper), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_keep(pin_keep));
  jtag_tester u_tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo), .tdo_oe(tdo_oe));

  // Per pin: output, output-disable, input; pin 0 leaves first
  function automatic logic [11:0] chain(input logic [3:0] o, input logic [3:0] e, input logic [3:0] p);
    chain = 12'h0;
    for (int i = 0; i < 4; i++) begin
      chain[3*i+:3] = {p[i], ~e[i], o[i]};
    end
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pins(input logic [3:0] o, input logic [3:0] e, input logic [3:0] c);
    check("pin out", {28'h0, o}, {28'h0, pin_out});
    check("pin enable", {28'h0, e}, {28'h0, pin_oe});
    check("core input", {28'h0, c}, {28'h0, core_in});
  endtask
  task automatic ir_load(input logic [9:0] op);
    u_tester.scan(1'b1, 10, {22'h0, op}, got);
    check("ir capture", 32'h1, got);
    check("tdo enable in shift", 32'h1, {31'h0, u_tester.oe_seen});
    check("tdo release", 32'h0, {31'h0, tdo_oe});
  endtask
  task automatic dr(input string name, input int n, input logic [31:0] din, input logic [31:0] exp);
    u_tester.scan(1'b0, n, din, got);
    check(name, exp, got);
  endtask
  // A slow crossing must not hang the run: bounded wait, loss counts as a mismatch
  task automatic wait_sig(input string name, input logic pulse, input logic want);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 80 && !seen; i++) begin
      @(negedge clock);
      seen = ((pulse ? restart : halt) === want);
    end
    check(name, 32'h1, {31'h0, seen});
    if (!seen) begin
      print_verdict();
    end
  endtask

  initial begin
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    u_tester.reset_tap();
    foreach (rows[i]) begin
      ir_load(rows[i].ir);
      dr("busy scan", int'(rows[i].len), rows[i].din, rows[i].dout);
      check("pins follow core", {28'h0, core_en}, {28'h0, pin_oe});
    end
    $display("test busy_modes done");
    ir_load(scan_pkg::OP_CONFIG_IO);
    wait_sig("halt set", 1'b0, 1'b1);
    ir_load(scan_pkg::OP_USERCODE);
    dr("default signature", 32, 32'h0, scan_pkg::SIG_DEFAULT);
    ir_load(scan_pkg::OP_SAMPLE);
    dr("sample capture", 24, 32'h00a315a6, {20'h5a6, chain(core_out, core_en, pin_in)});
    ir_load(scan_pkg::OP_EXTEST);
    pins(4'h9, 4'hd, 4'ha);
    dr("extest capture", 12, 32'h5ce, {20'h0, chain(4'h9, 4'hd, pin_in)});
    pins(4'h6, 4'h2, 4'h5);
    $display("test extest done");
    ir_load(scan_pkg::OP_CLAMP);
    dr("clamp bypass", 4, 32'hb, 32'h6);
    pins(4'h6, 4'h2, 4'h5);
    ir_load(scan_pkg::OP_HIGHZ);
    dr("highz bypass", 4, 32'h3, 32'h6);
    check("highz enable", 32'h0, {28'h0, pin_oe});
    $display("test clamp_highz done");
    // The restart pulse lands on the third clock after the update edge, after the instruction scan ends
    fork
      ir_load(scan_pkg::OP_PULSE_CFG);
      wait_sig("restart pulse", 1'b1, 1'b1);
    join
    // Interrupt again so that the pin, not the pulse, must clear the halt
    ir_load(scan_pkg::OP_CONFIG_IO);
    wait_sig("halt set again", 1'b0, 1'b1);
    @(negedge clock);
    req_n = 1'b0;
    u_tester.idle(8);
    wait_sig("halt cleared", 1'b0, 1'b0);
    done = 1'b1;
    req_n = 1'b1;
    // Keeper on a pin that clamp would otherwise drive
    keeper = 4'h2;
    u_tester.idle(8);
    ir_load(scan_pkg::OP_CLAMP);
    check("keeper", 32'h2, {28'h0, pin_keep});
    check("keeper beats clamp", 32'h0, {28'h0, pin_oe});
    ir_load(scan_pkg::OP_USERCODE);
    dr("user signature", 32, 32'h0, sig);
    $display("test configured done");
    u_tester.reset_tap();
    check("pins after reset", {28'h0, core_en}, {28'h0, pin_oe});
    dr("id after reset", 32, 32'h0, scan_pkg::ID_VALUE);
    $display("test reset done");
    print_verdict();
  end
endmodule
`default_nettype wire

//--- test/jtag_tester.sv
// Tester model: drives the test access port and reads the serial output
`timescale 1ns/10ps
`default_nettype none
module jtag_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_b,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic line = 1'b0;
  logic oe_now = 1'b0;
  logic oe_seen = 1'b0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_b = 1'b0;
  end
  // Clock stands low outside frames; a released output reads as the inverse of the previous sample
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    #32;
    line = tdo_oe ? tdo : ~line;
    oe_now = tdo_oe;
    tck = 1'b1;
    #32;
    tck = 1'b0;
  endtask
  // From idle to a shift state, n bits, then update and back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = 32'h0;
    oe_seen = 1'b1;
    tick(1'b1, 1'b0);
    if (ir) begin
      tick(1'b1, 1'b0);
    end
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = line;
      oe_seen = oe_seen & oe_now;
    end
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask
  task automatic reset_tap();
    trst_b = 1'b0;
    tick(1'b1, 1'b0);
    trst_b = 1'b1;
    repeat (5) tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask
  task automatic idle(input int n);
    repeat (n) tick(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire
